/* core/exec_pkg.sv */
package exec_pkg;

  // ----------------------------------------------------------------
  // Reset values and cycle figures
  // ----------------------------------------------------------------
  localparam logic [15:0] PC_RESET         = 16'h0000;
  localparam logic [7:0]  REG_RESET        = 8'h00;
  localparam int unsigned LOAD_CYCLES      = 2;
  localparam int unsigned STORE_CYCLES     = 2;
  localparam int unsigned BR_TAKEN_CYCLES  = 2;
  localparam logic [1:0]  STORE_EXTRA      = 2'(STORE_CYCLES - 1);
  localparam logic [1:0]  BR_TAKEN_EXTRA   = 2'(BR_TAKEN_CYCLES - 1);

  // ----------------------------------------------------------------
  // Status register bit positions
  // ----------------------------------------------------------------
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;
  localparam logic [2:0] FLAG_T = 3'h6;
  localparam logic [2:0] FLAG_I = 3'h7;

  // ----------------------------------------------------------------
  // Opcode masks and patterns
  // ----------------------------------------------------------------
  localparam logic [15:0] OP_COPY_M     = 16'hfc00;
  localparam logic [15:0] OP_COPY_P     = 16'h2c00;
  localparam logic [15:0] OP_PAIR_M     = 16'hff00;
  localparam logic [15:0] OP_PAIR_P     = 16'h0100;
  localparam logic [15:0] OP_IMM_M      = 16'hf000;
  localparam logic [15:0] OP_IMM_P      = 16'he000;
  localparam logic [15:0] OP_LDGRP_M    = 16'hfe00;
  localparam logic [15:0] OP_LDGRP_P    = 16'h9000;
  localparam logic [15:0] OP_STGRP_P    = 16'h9200;
  localparam logic [15:0] OP_DISP_M     = 16'hd200;
  localparam logic [15:0] OP_DISP_P     = 16'h8000;
  localparam logic [15:0] OP_STYZ_M     = 16'hfe07;
  localparam logic [15:0] OP_STYZ_P     = 16'h8200;
  localparam logic [15:0] OP_SKIP_M     = 16'hff00;
  localparam logic [15:0] OP_SKIPCLR_P  = 16'h9900;
  localparam logic [15:0] OP_SKIPSET_P  = 16'h9b00;
  localparam logic [15:0] OP_BR_M       = 16'hfc00;
  localparam logic [15:0] OP_BRSET_P    = 16'hf000;
  localparam logic [15:0] OP_BRCLR_P    = 16'hf400;
  localparam logic [15:0] OP_DIRECT_M   = 16'hfe0f;
  localparam logic [15:0] OP_DIRECT_P   = 16'h9000;
  localparam logic [15:0] OP_FAR_M      = 16'hfe0c;
  localparam logic [15:0] OP_FAR_P      = 16'h940c;

  // Low nibble of the load/store group: addressing mode
  localparam logic [3:0] NIB_DIRECT = 4'h0;
  localparam logic [3:0] NIB_Z_INC  = 4'h1;
  localparam logic [3:0] NIB_Z_DEC  = 4'h2;
  localparam logic [3:0] NIB_Y_INC  = 4'h9;
  localparam logic [3:0] NIB_Y_DEC  = 4'ha;
  localparam logic [3:0] NIB_X      = 4'hc;
  localparam logic [3:0] NIB_X_INC  = 4'hd;
  localparam logic [3:0] NIB_X_DEC  = 4'he;

  // Low register of each pointer pair
  localparam logic [4:0] PTR_X_LO = 5'h1a;
  localparam logic [4:0] PTR_Y_LO = 5'h1c;
  localparam logic [4:0] PTR_Z_LO = 5'h1e;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        we;
    logic        re;
  } dmem_req_t;

  typedef struct packed {
    logic        is_flow;
    logic        take;
    logic [15:0] step;
    logic [1:0]  extra;
  } flow_t;

  typedef enum logic [2:0] {
    ST_EXEC = 3'b001,
    ST_LOAD = 3'b010,
    ST_WAIT = 3'b100
  } exec_state_t;

endpackage

/* core/flow_unit.sv */
`timescale 1ns/1ps
module flow_unit import exec_pkg::*; (
  // Instruction words
  input  wire logic [15:0]  instr,
  input  wire logic [15:0]  instr_next,
  // Condition sources
  input  wire logic [7:0]   status_register,
  input  wire logic [255:0] io_regs,
  // Result
  output flow_t             flow
);

  logic       flag_val;
  logic       io_bit;
  logic       next_far;
  logic [2:0] sel;

  // ----------------------------------------------------------------
  // Branch and skip decisions
  // ----------------------------------------------------------------
  always_comb begin
    sel      = instr[2:0];
    io_bit   = io_regs[instr[7:0]];          // Port*8 + bit
    next_far = ((instr_next & OP_DIRECT_M) == OP_DIRECT_P) ||
               ((instr_next & OP_DIRECT_M) == (OP_DIRECT_P | 16'h0200)) ||
               ((instr_next & OP_FAR_M) == OP_FAR_P);
    unique case (sel)
      FLAG_Z: flag_val = status_register[FLAG_Z];   // [RULE_05]
      FLAG_C: flag_val = status_register[FLAG_C];   // [RULE_06]
      FLAG_N: flag_val = status_register[FLAG_N];   // [RULE_07] [RULE_08]
      // Signed test uses N xor V directly, not the stored S bit
      FLAG_S: flag_val = status_register[FLAG_N] ^
                         status_register[FLAG_V];   // [RULE_09]
      FLAG_H: flag_val = status_register[FLAG_H];   // [RULE_10]
      FLAG_T: flag_val = status_register[FLAG_T];   // [RULE_11]
      FLAG_V: flag_val = status_register[FLAG_V];   // [RULE_12]
      FLAG_I: flag_val = status_register[FLAG_I];   // [RULE_13]
    endcase
    flow = '0;
    if ((instr & OP_BR_M) == OP_BRSET_P) begin
      flow.is_flow = 1'b1;
      flow.take    = flag_val;                      // [RULE_03]
    end else if ((instr & OP_BR_M) == OP_BRCLR_P) begin
      flow.is_flow = 1'b1;
      flow.take    = ~flag_val;                     // [RULE_04] [RULE_08]
    end else if ((instr & OP_SKIP_M) == OP_SKIPCLR_P) begin
      flow.is_flow = 1'b1;
      flow.take    = ~io_bit;                       // [RULE_01]
    end else if ((instr & OP_SKIP_M) == OP_SKIPSET_P) begin
      flow.is_flow = 1'b1;
      flow.take    = io_bit;                        // [RULE_02]
    end
    // Step to add to pc, plus cycles beyond the first
    if (flow.is_flow && instr[15:12] == 4'hf) begin
      if (flow.take) begin
        // Signed 7-bit word offset relative to the next word
        flow.step  = {{9{instr[9]}}, instr[9:3]} + 16'h0001; // [RULE_21]
        flow.extra = BR_TAKEN_EXTRA;                // [RULE_03]
      end else begin
        flow.step  = 16'h0001;
      end
    end else if (flow.is_flow) begin
      if (flow.take) begin
        flow.step  = next_far ? 16'h0003 : 16'h0002; // [RULE_02]
        flow.extra = next_far ? 2'h2 : 2'h1;         // [RULE_01]
      end else begin
        flow.step  = 16'h0001;
      end
    end
  end

endmodule

/* core/branch_skip_load_store_exec.sv */
// Functional notes
// [RULE_01] Skip next if I/O bit clear, 1-3 cycles
// [RULE_02] Skip next if I/O bit set, 1-3 cycles
// [RULE_03] Branch if chosen flag set, 1/2 cycles
// [RULE_04] Branch if chosen flag clear, 1/2 cycles
// [RULE_05] Equal/not-equal branches test zero flag
// [RULE_06] Carry/lower/same-or-higher branches test carry flag
// [RULE_07] Minus branch taken when negative set
// [RULE_08] Plus branch taken when negative clear
// [RULE_09] Signed ge/lt branches test N xor V
// [RULE_10] Half-carry branches test half-carry flag
// [RULE_11] Transfer-bit branches test transfer flag
// [RULE_12] Overflow branches test overflow flag
// [RULE_13] Interrupt-state branches test interrupt enable flag
// [RULE_14] Copy, pair copy, immediate load: one cycle
// [RULE_15] Indirect load, then pointer plus one, 2 cycles
// [RULE_16] Pointer minus one, then indirect load, 2 cycles
// [RULE_17] Load at Y/Z plus displacement, pointer kept
// [RULE_18] Direct load from instruction address, 2 cycles
// [RULE_19] Indirect store, optional post-increment, 2 cycles
// [RULE_20] X pre-decrement store to decremented address
// [RULE_21] Branch offset is signed word displacement
`timescale 1ns/1ps
module branch_skip_load_store_exec import exec_pkg::*; (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         reset,
  // Instruction stream
  input  wire logic         instr_valid,
  input  wire logic [15:0]  instr,
  input  wire logic [15:0]  instr_next,
  output logic              instr_ready_q,
  output logic [15:0]       pc_q,
  output logic              illegal_q,
  // Core state from neighbouring logic
  input  wire logic [7:0]   status_register,
  input  wire logic [255:0] io_regs,
  // Data memory
  output dmem_req_t         dmem_q,
  input  wire logic [7:0]   dmem_rdata,
  // Register file peek
  input  wire logic [4:0]   peek_sel,
  output logic [7:0]        peek_data_q
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Pointer pair chosen by the load/store group low nibble
  function automatic logic [4:0] ptr_of(input logic [15:0] w);
    logic [4:0] idx;
    idx = PTR_Z_LO;
    if (w[3:2] == 2'b11) begin
      idx = PTR_X_LO;
    end else if (w[3]) begin
      idx = PTR_Y_LO;
    end
    return idx;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]   rf_q [32];
  exec_state_t  state_q;
  exec_state_t  state_d;
  logic [1:0]   wait_q;
  logic [4:0]   load_dst_q;

  flow_t        flow;
  logic         accept;
  logic         is_copy;
  logic         is_pair;
  logic         is_imm;
  logic         is_load;
  logic         is_store;
  logic         is_direct;
  logic         is_disp;
  logic         ptr_inc;
  logic         ptr_dec;
  logic [4:0]   ptr_idx;
  logic [4:0]   ptr_hi;
  logic [4:0]   rd;
  logic [4:0]   rr;
  logic [15:0]  ptr_val;
  logic [15:0]  ptr_new;
  logic [15:0]  mem_addr;
  logic [15:0]  disp;
  logic [15:0]  pc_step;
  logic [3:0]   nib;
  logic         legal;

  // ----------------------------------------------------------------
  // Branch and skip evaluation
  // ----------------------------------------------------------------
  flow_unit u_flow (
    .instr           (instr),
    .instr_next      (instr_next),
    .status_register (status_register),
    .io_regs         (io_regs),
    .flow            (flow)
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Instruction classes; Y/Z pre-decrement stores and nonzero-q
  // displaced stores belong to a neighbouring unit and read as illegal
  always_comb begin
    nib       = instr[3:0];
    accept    = instr_valid && instr_ready_q;
    rd        = instr[8:4];
    rr        = {instr[9], instr[3:0]};
    is_copy   = (instr & OP_COPY_M) == OP_COPY_P;
    is_pair   = (instr & OP_PAIR_M) == OP_PAIR_P;
    is_imm    = (instr & OP_IMM_M) == OP_IMM_P;
    is_direct = (instr & OP_DIRECT_M) == OP_DIRECT_P;
    is_disp   = (instr & OP_DISP_M) == OP_DISP_P;
    is_load   = is_direct || is_disp ||
                (((instr & OP_LDGRP_M) == OP_LDGRP_P) &&
                 (nib == NIB_Z_INC || nib == NIB_Z_DEC ||
                  nib == NIB_Y_INC || nib == NIB_Y_DEC ||
                  nib == NIB_X || nib == NIB_X_INC ||
                  nib == NIB_X_DEC));
    is_store  = ((instr & OP_STYZ_M) == OP_STYZ_P) ||
                (((instr & OP_LDGRP_M) == OP_STGRP_P) &&
                 (nib == NIB_Z_INC || nib == NIB_Y_INC ||
                  nib == NIB_X || nib == NIB_X_INC ||
                  nib == NIB_X_DEC));
    legal     = flow.is_flow || is_copy || is_pair || is_imm ||
                is_load || is_store;
  end

  // Pointer arithmetic and effective address
  always_comb begin
    if (is_disp || ((instr & OP_STYZ_M) == OP_STYZ_P)) begin
      ptr_idx = instr[3] ? PTR_Y_LO : PTR_Z_LO;
      ptr_inc = 1'b0;
      ptr_dec = 1'b0;
    end else begin
      ptr_idx = ptr_of(instr);
      ptr_inc = nib[1:0] == 2'b01;
      ptr_dec = nib[1:0] == 2'b10;
    end
    ptr_hi  = {ptr_idx[4:1], 1'b1};
    ptr_val = {rf_q[ptr_hi], rf_q[ptr_idx]};
    disp    = {10'h000, instr[13], instr[11:10], instr[2:0]};
    if (ptr_dec) begin
      ptr_new = ptr_val - 16'h0001;                 // [RULE_16] [RULE_20]
    end else if (ptr_inc) begin
      ptr_new = ptr_val + 16'h0001;                 // [RULE_15] [RULE_19]
    end else begin
      ptr_new = ptr_val;                            // [RULE_17]
    end
    if (is_direct) begin
      mem_addr = instr_next;                        // [RULE_18]
    end else if (ptr_dec) begin
      mem_addr = ptr_new;                           // [RULE_16] [RULE_20]
    end else if (is_disp) begin
      mem_addr = ptr_val + disp;                    // [RULE_17]
    end else begin
      mem_addr = ptr_val;                           // [RULE_15] [RULE_19]
    end
  end

  // Program counter step; the direct load spans two words
  always_comb begin
    if (flow.is_flow) begin
      pc_step = flow.step;
    end else if (is_direct) begin
      pc_step = 16'h0002;                           // [RULE_18]
    end else begin
      pc_step = 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Loads hold one cycle for data; stores, taken branches and
  // skips hold in the wait state for their extra cycles
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_EXEC: begin
        if (accept && is_load) begin
          state_d = ST_LOAD;                        // [RULE_15]
        end else if (accept && is_store) begin
          state_d = ST_WAIT;                        // [RULE_19]
        end else if (accept && flow.extra != 2'h0) begin
          state_d = ST_WAIT;                        // [RULE_03]
        end
      end
      ST_LOAD: begin
        state_d = ST_EXEC;
      end
      ST_WAIT: begin
        if (wait_q == 2'h1) begin
          state_d = ST_EXEC;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_q <= ST_EXEC;
    end else begin
      state_q <= state_d;
    end
  end

  // Ready follows the next state, so it is high only while idle
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      instr_ready_q <= 1'b0;
    end else begin
      instr_ready_q <= state_d == ST_EXEC;
    end
  end

  // Extra-cycle counter
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wait_q <= 2'h0;
    end else if (accept && is_store) begin
      wait_q <= STORE_EXTRA;                        // [RULE_19]
    end else if (accept) begin
      wait_q <= flow.extra;                         // [RULE_01] [RULE_02]
    end else if (state_q == ST_WAIT) begin
      wait_q <= wait_q - 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // Program counter and error flag
  // ----------------------------------------------------------------
  // Flags are never written here: no instruction of this unit
  // alters the status register
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pc_q <= PC_RESET;
    end else if (accept) begin
      pc_q <= pc_q + pc_step;                       // [RULE_03] [RULE_04]
    end
  end

  // Unknown words run as a one-word no-op and pulse this flag
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      illegal_q <= 1'b0;
    end else begin
      illegal_q <= accept && !legal;
    end
  end

  // ----------------------------------------------------------------
  // Data memory request
  // ----------------------------------------------------------------
  // Strobes last one cycle; address and data hold afterwards
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      dmem_q <= '0;
    end else begin
      dmem_q.re <= 1'b0;
      dmem_q.we <= 1'b0;
      if (accept && is_load) begin
        dmem_q.addr <= mem_addr;                    // [RULE_17] [RULE_18]
        dmem_q.re   <= 1'b1;                        // [RULE_15] [RULE_16]
      end else if (accept && is_store) begin
        dmem_q.addr  <= mem_addr;                   // [RULE_20]
        dmem_q.wdata <= rf_q[rd];                   // [RULE_19]
        dmem_q.we    <= 1'b1;                       // [RULE_19]
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      load_dst_q <= 5'h00;
    end else if (accept && is_load) begin
      load_dst_q <= rd;
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // Load data lands last, so it wins over a pointer update when the
  // destination is part of the pointer itself
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < 32; i++) begin
        rf_q[i] <= REG_RESET;
      end
    end else begin
      if (accept && is_copy) begin
        rf_q[rd] <= rf_q[rr];                       // [RULE_14]
      end
      if (accept && is_pair) begin
        rf_q[{instr[7:4], 1'b0}] <= rf_q[{instr[3:0], 1'b0}]; // [RULE_14]
        rf_q[{instr[7:4], 1'b1}] <= rf_q[{instr[3:0], 1'b1}]; // [RULE_14]
      end
      if (accept && is_imm) begin
        rf_q[{1'b1, instr[7:4]}] <= {instr[11:8], instr[3:0]}; // [RULE_14]
      end
      if (accept && (is_load || is_store) && (ptr_inc || ptr_dec)) begin
        rf_q[ptr_idx] <= ptr_new[7:0];              // [RULE_15] [RULE_16]
        rf_q[ptr_hi]  <= ptr_new[15:8];             // [RULE_19] [RULE_20]
      end
      if (state_q == ST_LOAD) begin
        rf_q[load_dst_q] <= dmem_rdata;             // [RULE_15] [RULE_18]
      end
    end
  end

  // Registered peek port for observing the register file
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      peek_data_q <= REG_RESET;
    end else begin
      peek_data_q <= rf_q[peek_sel];
    end
  end

endmodule

/* bench/exec_properties.sv */
`timescale 1ns/1ps
module exec_properties import exec_pkg::*; (
  // Clock and reset
  input wire logic         sys_clk,
  input wire logic         reset,
  // Instruction stream
  input wire logic         instr_valid,
  input wire logic [15:0]  instr,
  input wire logic [15:0]  instr_next,
  input wire logic         instr_ready_q,
  input wire logic [15:0]  pc_q,
  // Conditions and memory
  input wire logic [7:0]   status_register,
  input wire logic [255:0] io_regs,
  input wire dmem_req_t    dmem_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  // -----------------------------------------------------------
  // Decode of the accepted word
  // -----------------------------------------------------------
  logic        acc, bset, bclr, flg, ldg, stg, skc, sks, iob, cpy;
  logic [15:0] tgt;
  assign acc  = instr_valid && instr_ready_q;
  assign tgt  = pc_q + 16'h0001 + {{9{instr[9]}}, instr[9:3]};
  assign bset = acc && (instr & OP_BR_M) == OP_BRSET_P;
  assign bclr = acc && (instr & OP_BR_M) == OP_BRCLR_P;
  assign flg  = status_register[instr[2:0]];
  assign ldg  = acc && (instr & OP_LDGRP_M) == OP_LDGRP_P;
  assign stg  = acc && (instr & OP_LDGRP_M) == OP_STGRP_P;
  assign skc  = acc && (instr & OP_SKIP_M) == OP_SKIPCLR_P;
  assign sks  = acc && (instr & OP_SKIP_M) == OP_SKIPSET_P;
  assign iob  = io_regs[instr[7:0]];
  assign cpy  = acc && (instr & OP_COPY_M) == OP_COPY_P;

  property p_br_set;
    bset && flg |=> pc_q == $past(tgt) && !instr_ready_q ##1 instr_ready_q;
  endproperty
  a_br_set: assert property (p_br_set)
    else $error("taken set branch target or timing wrong");
  property p_br_clr_fall;
    bclr && flg |=> pc_q == $past(pc_q) + 16'h0001 && instr_ready_q;
  endproperty
  a_br_clr_fall: assert property (p_br_clr_fall)
    else $error("untaken clear branch wrong");
  property p_br_clr_take;
    bclr && !flg |=> pc_q == $past(tgt) && !instr_ready_q;
  endproperty
  a_br_clr_take: assert property (p_br_clr_take)
    else $error("taken clear branch target wrong");
  property p_copy;
    cpy |=> instr_ready_q && pc_q == $past(pc_q) + 16'h0001 && !dmem_q.re;
  endproperty
  a_copy: assert property (p_copy)
    else $error("register copy not single cycle");
  property p_skip_clr;
    skc && !iob |=> 16'(pc_q - $past(pc_q)) inside {16'h0002, 16'h0003};
  endproperty
  a_skip_clr: assert property (p_skip_clr)
    else $error("skip on clear bit did not skip");
  property p_skip_set;
    sks && !iob |=> pc_q == $past(pc_q) + 16'h0001 && instr_ready_q;
  endproperty
  a_skip_set: assert property (p_skip_set)
    else $error("skip on set bit skipped wrongly");
  property p_ld_dec;
    ldg && instr[3:0] == NIB_X_DEC |=> dmem_q.re && !dmem_q.we
      && !instr_ready_q ##1 instr_ready_q && !dmem_q.re;
  endproperty
  a_ld_dec: assert property (p_ld_dec)
    else $error("pre-decrement load timing wrong");
  property p_lds;
    ldg && instr[3:0] == NIB_DIRECT |=> dmem_q.re
      && dmem_q.addr == $past(instr_next) && pc_q == $past(pc_q) + 16'h0002;
  endproperty
  a_lds: assert property (p_lds)
    else $error("direct load address or pc wrong");
  property p_st_x;
    stg && instr[3:0] == NIB_X |=> dmem_q.we && !dmem_q.re
      ##1 !dmem_q.we && instr_ready_q;
  endproperty
  a_st_x: assert property (p_st_x)
    else $error("indirect store timing wrong");
endmodule

bind branch_skip_load_store_exec exec_properties chk (
  .sys_clk(sys_clk), .reset(reset), .instr_valid(instr_valid),
  .instr(instr), .instr_next(instr_next), .instr_ready_q(instr_ready_q),
  .pc_q(pc_q), .status_register(status_register), .io_regs(io_regs),
  .dmem_q(dmem_q));

/* bench/data_mem_model.sv */
`timescale 1ns/1ps
module data_mem_model import exec_pkg::*; (
  // Clock
  input wire logic      sys_clk,
  // Request and answer
  input wire dmem_req_t dmem_q,
  output logic [7:0]    dmem_rdata
);
  logic [7:0] mem [65536];

  // Known fill so the bench can predict loads
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h5a;
  end

  always @(posedge sys_clk) begin
    if (dmem_q.we) mem[dmem_q.addr] <= dmem_q.wdata;
  end

  // Outside the read cycle show the inverse, never stale data
  always_comb begin
    dmem_rdata = dmem_q.re ? mem[dmem_q.addr] : ~mem[dmem_q.addr];
  end
endmodule

/* bench/tb_branch_skip_load_store_exec.sv */
`timescale 1ns/1ps
module tb_branch_skip_load_store_exec import exec_pkg::*;;
  logic         sys_clk, reset, instr_valid, instr_ready_q, illegal_q;
  logic [15:0]  instr, instr_next, pc_q, pc;
  logic [7:0]   status_register, dmem_rdata, peek_data_q;
  logic [255:0] io_regs;
  logic [4:0]   peek_sel;
  dmem_req_t    dmem_q;
  logic [7:0]   rf [32];
  logic [7:0]   shadow [logic [15:0]];
  logic [15:0]  pcq [$];
  logic [24:0]  mq [$];
  int           error_cnt = 0;
  int           checks_done = 0;

  branch_skip_load_store_exec dut (.sys_clk(sys_clk), .reset(reset),
    .instr_valid(instr_valid), .instr(instr), .instr_next(instr_next),
    .instr_ready_q(instr_ready_q), .pc_q(pc_q), .illegal_q(illegal_q),
    .status_register(status_register), .io_regs(io_regs),
    .dmem_q(dmem_q), .dmem_rdata(dmem_rdata), .peek_sel(peek_sel),
    .peek_data_q(peek_data_q));
  data_mem_model mem (.sys_clk(sys_clk), .dmem_q(dmem_q),
    .dmem_rdata(dmem_rdata));

  initial begin
    sys_clk = 0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // -----------------------------------------------------------
  // Checking and closing
  // -----------------------------------------------------------
  task automatic chk(string what, logic [24:0] seen, logic [24:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run;
    $display("Checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  function automatic logic [7:0] memv(logic [15:0] a);
    return shadow.exists(a) ? shadow[a] : a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction

  // Watch pc after each accept and every memory strobe
  always @(posedge sys_clk) begin
    if (reset === 1'b0 && instr_valid === 1'b1 && instr_ready_q === 1'b1)
    begin
      #2;
      chk("pc", {pc_q, illegal_q}, {pcq.pop_front(), 1'b0});
    end
  end
  always @(posedge sys_clk) begin
    #2;
    if (dmem_q.re === 1'b1 || dmem_q.we === 1'b1)
      chk("mem", {dmem_q.addr, dmem_q.we, dmem_q.we ? dmem_q.wdata : 8'h00},
          mq.size() ? mq.pop_front() : '1);
  end

  // Offer one word once the unit is idle, note the next pc
  task automatic issue(logic [15:0] w0, logic [15:0] w1, logic [15:0] np);
    int n;
    n = 0;
    while (instr_ready_q !== 1'b1 && n < 20) begin
      instr_valid = 0;
      instr = 16'($urandom);
      @(posedge sys_clk);
      #1;
      n++;
    end
    instr_valid = 1;
    instr = w0;
    instr_next = w1;
    pc = np;
    pcq.push_back(np);
    @(posedge sys_clk);
    #1;
  endtask

  // p: 0 X, 1 Y, 2 Z, 3 direct; m: 1 post-inc, 2 pre-dec
  task automatic memop(logic [15:0] w0, logic [15:0] k, bit st, int p,
                       int m, int q, int r);
    logic [15:0] a;
    a = (p == 3) ? k : {rf[27 + 2 * p], rf[26 + 2 * p]};
    if (m == 2) a--;
    if (m == 2) {rf[27 + 2 * p], rf[26 + 2 * p]} = a;
    if (st) mq.push_back({a + 16'(q), 1'b1, rf[r]});
    if (st) shadow[a + 16'(q)] = rf[r];
    else mq.push_back({a + 16'(q), 9'h000});
    if (!st) rf[r] = memv(a + 16'(q));
    if (m == 1) {rf[27 + 2 * p], rf[26 + 2 * p]} = a + 16'h1;
    issue(w0, k, pc + ((p == 3) ? 16'h2 : 16'h1));
  endtask

  initial begin
    #100000;
    error_cnt++;
    complete_run();
  end

  // -----------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------
  initial begin
    logic [7:0]  k;
    logic [3:0]  nib [7];
    int          pp [7];
    int          mm [7];
    logic [15:0] w;
    bit          sk;
    nib = '{4'hc, 4'hd, 4'he, 4'h9, 4'ha, 4'h1, 4'h2};
    pp  = '{0, 0, 0, 1, 1, 2, 2};
    mm  = '{0, 1, 2, 1, 2, 1, 2};
    void'($urandom(3464));
    reset = 1;
    instr_valid = 0;
    instr = 0;
    instr_next = 0;
    status_register = 0;
    io_regs = 0;
    peek_sel = 0;
    pc = 0;
    foreach (rf[i]) rf[i] = 8'h00;
    repeat (6) @(posedge sys_clk);
    #1;
    reset = 0;
    chk("pc_reset", 25'(pc_q), 25'h0);
    // Immediate loads, copies and pair copies
    for (int d = 16; d < 32; d++) begin
      k = 8'($urandom);
      rf[d] = k;
      issue({4'he, k[7:4], 4'(d - 16), k[3:0]}, 0, pc + 1);
    end
    for (int d = 0; d < 8; d++) begin
      w = 16'($urandom_range(16, 31));
      rf[d] = rf[w];
      issue({6'b001011, w[4], 5'(d), w[3:0]}, 0, pc + 1);
    end
    {rf[9], rf[8]} = {rf[21], rf[20]};
    issue(16'h014a, 0, pc + 1);
    // Every flag, both polarities, both flag levels
    for (int i = 0; i < 32; i++) begin
      k = 8'($urandom);
      status_register = 8'($urandom);
      status_register[i % 8] = i[4];
      if (i % 8 == 4) status_register[3] = status_register[2] ^ i[4];
      sk = i[4] ^ i[3];
      issue({5'b11110, i[3], k[6:0], 3'(i)},
            0, pc + 1 + (sk ? {{9{k[6]}}, k[6:0]} : 16'h0));
    end
    // I/O bit skips over one- and two-word followers
    for (int i = 0; i < 16; i++) begin
      io_regs = {8{32'($urandom)}};
      k = 8'($urandom);
      sk = io_regs[k] == i[0];
      issue(16'h9900 | {6'h0, i[0], 1'b0, k}, i[1] ? 16'h9000 : 16'h2c00,
            pc + 1 + (sk ? (i[1] ? 16'h2 : 16'h1) : 16'h0));
    end
    // Loads, indirect and displaced and direct
    for (int i = 0; i < 7; i++) begin
      w = 16'(i + 1);
      memop(16'h9000 | {7'h0, w[4:0], nib[i]}, 0, 0, pp[i], mm[i], 0, i + 1);
      k = 8'($urandom_range(0, 63));
      memop({2'b10, k[5], 1'b0, k[4:3], 2'b00, w[3:0], i[0], k[2:0]},
            0, 0, 2 - i[0], 0, k, i + 1);
    end
    memop(16'h9000 | 16'h0050, 16'($urandom), 0, 3, 0, 0, 5);
    // Stores through all three pointers
    for (int i = 0; i < 7; i++)
      if (mm[i] != 2 || pp[i] == 0)
        memop(16'h9200 | {7'h0, 5'(i + 8), nib[i]}, 0, 1, pp[i], mm[i],
              0, i + 8);
    memop(16'h8270, 0, 1, 2, 0, 0, 7);
    memop(16'h8278, 0, 1, 1, 0, 0, 7);
    instr_valid = 0;
    repeat (3) @(posedge sys_clk);
    #1;
    // Whole register file through the peek port
    for (int i = 0; i < 32; i++) begin
      peek_sel = 5'(i);
      @(posedge sys_clk);
      #1;
      chk("reg", 25'(peek_data_q), 25'(rf[i]));
    end
    chk("left", 25'(pcq.size() + mq.size()), 25'h0);
    complete_run();
  end
endmodule
